// file: hw/pesec_map.vh
`ifndef PESEC_MAP_VH
`define PESEC_MAP_VH

// Register bus geometry
`define PESEC_ADDR_W 8
`define PESEC_IDX_W 6
`define PESEC_IDX_LSB 2

// Register indexes; byte address is four times the index
`define PESEC_IDX_STAT1 6'h12
`define PESEC_IDX_STAT2 6'h13
`define PESEC_IDX_FCNT 6'h14
`define PESEC_IDX_RECNT 6'h15
`define PESEC_IDX_CTRL 6'h20

// Second status register: latched flags
`define PESEC_S2_UV 15
`define PESEC_S2_OV 14
`define PESEC_S2_OT 11
`define PESEC_S2_SLEEP 10
`define PESEC_S2_POL 9
`define PESEC_S2_JAB 8

// Second status register: enables
`define PESEC_S2_UV_EN 7
`define PESEC_S2_OV_EN 6
`define PESEC_S2_OT_EN 3
`define PESEC_S2_SLEEP_EN 2
`define PESEC_S2_POL_EN 1
`define PESEC_S2_JAB_EN 0

// First status register: counter half-full flags and enables
`define PESEC_S1_FC_HF 9
`define PESEC_S1_RE_HF 8
`define PESEC_S1_FC_HF_EN 1
`define PESEC_S1_RE_HF_EN 0

// Control register
`define PESEC_CTRL_LOOP 0

// Counters
`define PESEC_FC_W 8
`define PESEC_FC_HALF 8'h7f
`define PESEC_RE_W 16
`define PESEC_RE_HALF 16'h7fff

// Reset values
`define PESEC_RST_FLAGS2 6'h00
`define PESEC_RST_EN2 6'h00
`define PESEC_RST_FLAGS1 2'h0
`define PESEC_RST_EN1 2'h0
`define PESEC_RST_CTRL 1'b0

// Bus responses
`define PESEC_RESP_OKAY 2'b00
`define PESEC_RESP_SLVERR 2'b10

`endif

// file: hw/pesec_sat_counter.v
`timescale 1ns/1ps
module pesec_sat_counter #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] HALF = {1'b0, {(WIDTH-1){1'b1}}}
) (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire inc_i,
    input wire clr_i,
    output reg [WIDTH-1:0] count_o,
    output wire half_full_o
);

    wire at_max;
    reg [WIDTH-1:0] next_count;

    assign at_max = (count_o == {WIDTH{1'b1}});

    // One pulse as the count steps past the half-full point
    assign half_full_o = inc_i & ~clr_i & (count_o == HALF);

    always @* begin
        if (clr_i) begin
            // A read that meets an event keeps that event
            next_count = inc_i ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        end else if (inc_i && !at_max) begin
            next_count = count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            next_count = count_o;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            count_o <= {WIDTH{1'b0}};
        end else begin
            count_o <= next_count;
        end
    end

endmodule

// file: hw/pesec_top.v
// Functional notes
// - Undervoltage flag latches high at bit 15
// - Overvoltage flag latches high at bit 14
// - Overtemperature flag latches high at bit 11
// - Sleep-mode event flag latches at bit 10
// - Polarity change flag latches at bit 9
// - Jabber flag latches high at bit 8
// - Enables at bits 7, 6, reset zero
// - Enables at bits 3..0, reset zero
// - Receive-error half-full enable, first register bit 0
// - 8-bit false-carrier counter, cleared on read
// - False-carrier counter saturates at all ones
// - False-carrier half-full event above 0x7f
// - Receive-error counter counts valid-carrier symbol errors
// - No receive-error counting during MAC-side loopback
// - Receive-error counter saturates, no wrap
// - Receive-error half-full event above 0x7fff
// - Receive-error half-full flag, first register bit 8
// - False-carrier half-full flag, first register bit 9
// - False-carrier half-full enable, first register bit 1
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pesec_map.vh"

module pesec_top (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire [`PESEC_ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [`PESEC_ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire undervoltage_evt_i,
    input wire overvoltage_evt_i,
    input wire overtemp_evt_i,
    input wire sleep_evt_i,
    input wire polarity_evt_i,
    input wire jabber_evt_i,
    input wire false_carrier_evt_i,
    input wire rx_data_valid_i,
    input wire rx_symbol_error_i,
    output reg irq_o,
    output reg mac_loopback_o
);

    // Flag and enable vectors, msb first: uv, ov, ot, sleep, pol, jabber
    reg [5:0] flags_two;
    reg [5:0] enables_two;
    reg [5:0] next_flags_two;
    // Index 1 is false-carrier half-full, index 0 receive-error half-full
    reg [1:0] flags_one;
    reg [1:0] enables_one;
    reg [1:0] next_flags_one;
    wire [5:0] events_two;
    wire [1:0] events_one;

    // Write channel state
    reg aw_have;
    reg w_have;
    reg [`PESEC_IDX_W-1:0] aw_idx;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire aw_take;
    wire w_take;
    wire wr_do;
    wire wr_lane0;
    wire wr_mapped;
    wire wr_stat1;
    wire wr_stat2;
    wire wr_ctrl;

    // Read channel
    wire ar_take;
    wire [`PESEC_IDX_W-1:0] rd_idx;
    reg [31:0] rd_word;
    reg rd_mapped;
    wire rd_clr_one;
    wire rd_clr_two;
    wire rd_clr_fc;
    wire rd_clr_re;

    // Counters
    wire [`PESEC_FC_W-1:0] fc_count;
    wire [`PESEC_RE_W-1:0] re_count;
    wire fc_half_full;
    wire re_half_full;
    wire re_inc;
    wire irq_pending;
    wire irq_pending_one;
    wire irq_pending_two;
    wire rx_error_seen;

    // AXI4-Lite write side
    assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take = s_axi_wvalid_i & s_axi_wready_o;
    assign wr_do = aw_have & w_have & ~s_axi_bvalid_o;
    assign wr_lane0 = wr_do & w_strb[0];
    // Writable bits all sit in byte lane 0
    assign wr_stat1 = wr_lane0 && (aw_idx == `PESEC_IDX_STAT1);
    assign wr_stat2 = wr_lane0 && (aw_idx == `PESEC_IDX_STAT2);
    assign wr_ctrl = wr_lane0 && (aw_idx == `PESEC_IDX_CTRL);

    // Unmapped indexes answer with an error and change nothing
    assign wr_mapped = (aw_idx == `PESEC_IDX_STAT1) ||
                       (aw_idx == `PESEC_IDX_STAT2) ||
                       (aw_idx == `PESEC_IDX_FCNT) ||
                       (aw_idx == `PESEC_IDX_RECNT) ||
                       (aw_idx == `PESEC_IDX_CTRL);

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_axi_awready_o <= 1'b1;
            aw_have <= 1'b0;
            aw_idx <= {`PESEC_IDX_W{1'b0}};
        end else begin
            if (aw_take) begin
                s_axi_awready_o <= 1'b0;
                aw_have <= 1'b1;
                aw_idx <= s_axi_awaddr_i[`PESEC_ADDR_W-1:`PESEC_IDX_LSB];
            end else if (wr_do) begin
                aw_have <= 1'b0;
            end
            // Address is taken again only after the response is gone
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_awready_o <= 1'b1;
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_axi_wready_o <= 1'b1;
            w_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (w_take) begin
                s_axi_wready_o <= 1'b0;
                w_have <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end else if (wr_do) begin
                w_have <= 1'b0;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `PESEC_RESP_OKAY;
        end else begin
            if (wr_do) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_mapped ? `PESEC_RESP_OKAY : `PESEC_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Enables live in the low byte; the upper byte holds read-only flags
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            enables_two <= `PESEC_RST_EN2;
        end else if (wr_stat2) begin
            enables_two[5] <= w_data[`PESEC_S2_UV_EN];
            enables_two[4] <= w_data[`PESEC_S2_OV_EN];
            enables_two[3] <= w_data[`PESEC_S2_OT_EN];
            enables_two[2] <= w_data[`PESEC_S2_SLEEP_EN];
            enables_two[1] <= w_data[`PESEC_S2_POL_EN];
            enables_two[0] <= w_data[`PESEC_S2_JAB_EN];
        end
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            enables_one <= `PESEC_RST_EN1;
        end else if (wr_stat1) begin
            enables_one[1] <= w_data[`PESEC_S1_FC_HF_EN];
            enables_one[0] <= w_data[`PESEC_S1_RE_HF_EN];
        end
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mac_loopback_o <= `PESEC_RST_CTRL;
        end else if (wr_ctrl) begin
            mac_loopback_o <= w_data[`PESEC_CTRL_LOOP];
        end
    end

    // AXI4-Lite read side
    assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
    assign rd_idx = s_axi_araddr_i[`PESEC_ADDR_W-1:`PESEC_IDX_LSB];

    // Clears act on the same edge that captures the read data
    assign rd_clr_one = ar_take && (rd_idx == `PESEC_IDX_STAT1);
    assign rd_clr_two = ar_take && (rd_idx == `PESEC_IDX_STAT2);
    assign rd_clr_fc = ar_take && (rd_idx == `PESEC_IDX_FCNT);
    assign rd_clr_re = ar_take && (rd_idx == `PESEC_IDX_RECNT);

    always @* begin
        rd_word = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (rd_idx)
            `PESEC_IDX_STAT1: begin
                rd_word[`PESEC_S1_FC_HF] = flags_one[1];
                rd_word[`PESEC_S1_RE_HF] = flags_one[0];
                rd_word[`PESEC_S1_FC_HF_EN] = enables_one[1];
                rd_word[`PESEC_S1_RE_HF_EN] = enables_one[0];
            end
            `PESEC_IDX_STAT2: begin
                rd_word[`PESEC_S2_UV] = flags_two[5];
                rd_word[`PESEC_S2_OV] = flags_two[4];
                rd_word[`PESEC_S2_OT] = flags_two[3];
                rd_word[`PESEC_S2_SLEEP] = flags_two[2];
                rd_word[`PESEC_S2_POL] = flags_two[1];
                rd_word[`PESEC_S2_JAB] = flags_two[0];
                rd_word[`PESEC_S2_UV_EN] = enables_two[5];
                rd_word[`PESEC_S2_OV_EN] = enables_two[4];
                rd_word[`PESEC_S2_OT_EN] = enables_two[3];
                rd_word[`PESEC_S2_SLEEP_EN] = enables_two[2];
                rd_word[`PESEC_S2_POL_EN] = enables_two[1];
                rd_word[`PESEC_S2_JAB_EN] = enables_two[0];
            end
            `PESEC_IDX_FCNT: begin
                rd_word[`PESEC_FC_W-1:0] = fc_count;
            end
            `PESEC_IDX_RECNT: begin
                rd_word[`PESEC_RE_W-1:0] = re_count;
            end
            `PESEC_IDX_CTRL: begin
                rd_word[`PESEC_CTRL_LOOP] = mac_loopback_o;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // No new address while data stands, so the cleared word is never lost
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `PESEC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_mapped ? `PESEC_RESP_OKAY : `PESEC_RESP_SLVERR;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_arready_o <= 1'b1;
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Error counters
    // Symbol errors count only inside a valid frame and never in loopback
    assign rx_error_seen = rx_data_valid_i & rx_symbol_error_i;
    assign re_inc = rx_error_seen & ~mac_loopback_o;

    pesec_sat_counter #(
        .WIDTH(`PESEC_FC_W),
        .HALF(`PESEC_FC_HALF)
    ) u_false_carrier (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .inc_i(false_carrier_evt_i),
        .clr_i(rd_clr_fc),
        .count_o(fc_count),
        .half_full_o(fc_half_full)
    );

    pesec_sat_counter #(
        .WIDTH(`PESEC_RE_W),
        .HALF(`PESEC_RE_HALF)
    ) u_receive_error (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .inc_i(re_inc),
        .clr_i(rd_clr_re),
        .count_o(re_count),
        .half_full_o(re_half_full)
    );

    // Latched-high flags
    assign events_two = {undervoltage_evt_i, overvoltage_evt_i, overtemp_evt_i,
                         sleep_evt_i, polarity_evt_i, jabber_evt_i};
    // Counter half-full pulses feed the first register's flags
    assign events_one = {fc_half_full, re_half_full};

    // A new event in the read cycle survives the clear
    always @* begin
        next_flags_two = (flags_two & ~{6{rd_clr_two}}) | events_two;
        next_flags_one = (flags_one & ~{2{rd_clr_one}}) | events_one;
    end

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            flags_two <= `PESEC_RST_FLAGS2;
            flags_one <= `PESEC_RST_FLAGS1;
        end else begin
            flags_two <= next_flags_two;
            flags_one <= next_flags_one;
        end
    end

    // Interrupt request, one flop behind the flags so the pin never glitches
    assign irq_pending_two = |(flags_two & enables_two);
    assign irq_pending_one = |(flags_one & enables_one);
    assign irq_pending = irq_pending_two | irq_pending_one;

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_pending;
        end
    end

endmodule

// file: sim/pesec_assertions.sv
`timescale 1ns/1ps
module pesec_assertions (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire undervoltage_evt_i,
    input wire overvoltage_evt_i,
    input wire overtemp_evt_i,
    input wire sleep_evt_i,
    input wire polarity_evt_i,
    input wire jabber_evt_i,
    input wire false_carrier_evt_i,
    input wire rx_data_valid_i,
    input wire rx_symbol_error_i,
    input wire irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    reg [3:0] hist;
    wire evt;
    // Any cause that can set a flag, kept for a few cycles
    assign evt = undervoltage_evt_i | overvoltage_evt_i | overtemp_evt_i | sleep_evt_i
        | polarity_evt_i | jabber_evt_i | false_carrier_evt_i
        | (rx_data_valid_i & rx_symbol_error_i);
    always @(posedge clk_sys_i) begin
        hist <= resetn_i ? {hist[2:0], evt} : 4'h0;
    end
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data not held");
    r_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i
        |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("read not closed");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> !s_axi_awready_o ##1 s_axi_bvalid_o) else $error("write answer");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    b_done_a: assert property (s_axi_bvalid_o && s_axi_bready_i
        |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o) else $error("write not closed");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(s_axi_bvalid_o)
        || $past(s_axi_arvalid_i && s_axi_arready_o, 2)) else $error("interrupt dropped");
    irq_rise_a: assert property ($rose(irq_o) |-> (|hist[3:1]) || $past(s_axi_bvalid_o))
        else $error("interrupt without cause");
endmodule

// file: sim/pesec_top_tb.sv
`timescale 1ns/1ps
`include "pesec_map.vh"
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, x, g); end end
module pesec_top_tb;
    reg clk_sys_i = 0;
    reg resetn_i = 0;
    reg [7:0] awaddr = 0;
    reg [7:0] araddr = 0;
    reg [31:0] wdata = 0;
    reg [3:0] wstrb = 0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg [5:0] evt = 0;
    reg fc = 0, dv = 0, er = 0, v, e, f;
    wire awready, wready, bvalid, arready, rvalid, irq, loopb;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer error_cnt = 0, tests_run = 0, i, n, nf;
    reg [31:0] d, en;
    reg [1:0] r;
    always #5 clk_sys_i = ~clk_sys_i;
    pesec_top i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .undervoltage_evt_i(evt[5]), .overvoltage_evt_i(evt[4]),
        .overtemp_evt_i(evt[3]), .sleep_evt_i(evt[2]), .polarity_evt_i(evt[1]),
        .jabber_evt_i(evt[0]), .false_carrier_evt_i(fc), .rx_data_valid_i(dv),
        .rx_symbol_error_i(er), .irq_o(irq), .mac_loopback_o(loopb));
    function [31:0] fbit(input integer k);
        fbit = 32'h1 << (k < 4 ? 8 + k : 10 + k);
    endfunction
    task wr(input [7:0] a, input [31:0] val, input [3:0] s);
        begin
            @(posedge clk_sys_i);
            awaddr <= a;
            wdata <= val;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            // Ready follows the response a cycle late, so the response must stand
            do begin
                @(posedge clk_sys_i);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
            end while (bvalid !== 1'b1 || bready !== 1'b1);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk_sys_i);
            araddr <= a;
            arvalid <= 1'b1;
            do begin
                @(posedge clk_sys_i);
                if (arready) arvalid <= 1'b0;
                if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
            end while (rvalid !== 1'b1 || rready !== 1'b1);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
    task rc(input [7:0] a, input [31:0] x);
        begin
            rd(a);
            `CHK("reg_read", x, d)
        end
    endtask
    task drv(input [5:0] m, input fi, input vi, input ei, input integer k);
        begin
            @(posedge clk_sys_i);
            evt <= m;
            fc <= fi;
            dv <= vi;
            er <= ei;
            repeat (k) @(posedge clk_sys_i);
            evt <= 6'h00;
            fc <= 1'b0;
            dv <= 1'b0;
            er <= 1'b0;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        error_cnt++;
        print_verdict;
    end
    initial begin
        void'($urandom(37211));
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 5; i++) rc(i == 4 ? 8'h80 : 8'h48 + 4 * i, 0);
        wr(8'h00, 32'hffffffff, 4'hf);
        `CHK("bresp", `PESEC_RESP_SLVERR, r)
        rc(8'h00, 0);
        `CHK("rresp", `PESEC_RESP_SLVERR, r)
        en = $urandom;
        wr(8'h4c, en, 4'hf);
        rc(8'h4c, en & 32'hcf);
        `CHK("rresp", `PESEC_RESP_OKAY, r)
        wr(8'h4c, ~en, 4'h0);
        rc(8'h4c, en & 32'hcf);
        wr(8'h48, en, 4'hf);
        rc(8'h48, en & 32'h3);
        wr(8'h48, 0, 4'hf);
        wr(8'h4c, 0, 4'hf);
        for (i = 0; i < 6; i++) begin
            drv(6'h01 << i, 0, 0, 0, 1 + $urandom % 3);
            rc(8'h4c, fbit(i));
            rc(8'h4c, 0);
        end
        wr(8'h4c, 1, 4'hf);
        drv(6'h01, 0, 0, 0, 1);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("irq", 1'b1, irq)
        drv(6'h10, 0, 0, 0, 1);
        rc(8'h4c, 32'h4101);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("irq", 1'b0, irq)
        drv(6'h10, 0, 0, 0, 1);
        repeat (3) @(posedge clk_sys_i);
        #1 `CHK("irq", 1'b0, irq)
        rc(8'h4c, 32'h4001);
        n = 1 + $urandom % 100;
        drv(0, 1, 0, 0, n);
        rc(8'h50, n);
        rc(8'h50, 0);
        drv(0, 1, 0, 0, 127);
        rc(8'h48, 0);
        drv(0, 1, 0, 0, 1);
        rc(8'h48, 32'h200);
        rc(8'h50, 32'h80);
        wr(8'h50, 32'h55, 4'hf);
        `CHK("bresp", `PESEC_RESP_OKAY, r)
        rc(8'h50, 0);
        drv(0, 1, 0, 0, 300);
        rc(8'h50, 32'hff);
        rc(8'h48, 32'h200);
        drv(0, 0, 1, 0, 5);
        drv(0, 0, 0, 1, 5);
        drv(0, 0, 1, 1, 7);
        rc(8'h54, 7);
        wr(8'h80, 1, 4'hf);
        `CHK("loopback", 1'b1, loopb)
        drv(0, 0, 1, 1, 9);
        rc(8'h54, 0);
        wr(8'h80, 0, 4'hf);
        n = 0;
        nf = 0;
        for (i = 0; i < 120; i++) begin
            @(posedge clk_sys_i);
            v = $urandom % 2;
            e = $urandom % 2;
            f = $urandom % 2;
            dv <= v;
            er <= e;
            fc <= f;
            n = n + (v & e);
            nf = nf + f;
        end
        drv(0, 0, 0, 0, 1);
        rc(8'h54, n);
        rc(8'h50, nf);
        drv(0, 0, 1, 1, 65600);
        rc(8'h54, 32'hffff);
        rc(8'h48, 32'h100);
        print_verdict;
    end
endmodule
bind pesec_top pesec_assertions i_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .undervoltage_evt_i(undervoltage_evt_i),
    .overvoltage_evt_i(overvoltage_evt_i), .overtemp_evt_i(overtemp_evt_i),
    .sleep_evt_i(sleep_evt_i), .polarity_evt_i(polarity_evt_i), .jabber_evt_i(jabber_evt_i),
    .false_carrier_evt_i(false_carrier_evt_i), .rx_data_valid_i(rx_data_valid_i),
    .rx_symbol_error_i(rx_symbol_error_i), .irq_o(irq_o));
